// ### include/ssbp_defs.svh
// constants for the synchronous burst sram port
`ifndef SSBP_DEFS_SVH
`define SSBP_DEFS_SVH
`define SSBP_ADDR_W 15
`define SSBP_DEPTH 32768
`define SSBP_DATA_W 36
`define SSBP_LANES 4
`define SSBP_LANE_W 9
`define SSBP_CNT_W 2
`define SSBP_HI_W 13
`define SSBP_LOW_MSB 1
`define SSBP_HI_LSB 2
`define SSBP_HI_MSB 14
`define SSBP_CNT_RST 2'h0
`define SSBP_CNT_STEP 2'h1
`define SSBP_CNT_LAST 2'h3
`define SSBP_MASK_ALL 4'hF
`define SSBP_MASK_NONE 4'h0
`endif

// ### include/ssbp_pkg.sv
// types for the synchronous burst sram port
package ssbp_pkg;
  typedef enum {
    CYC_DESEL,
    CYC_READ,
    CYC_WRITE
  } ssbp_cycle_t;
endpackage

// ### rtl/ssbp_array.sv
// word array with per-lane byte write
`timescale 1ns/1ns
`default_nettype none
`include "ssbp_defs.svh"
module ssbp_array (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [`SSBP_LANES-1:0] wr_mask,
  input wire logic [`SSBP_DATA_W-1:0] wr_data,
  input wire logic [`SSBP_ADDR_W-1:0] addr,
  output logic [`SSBP_DATA_W-1:0] rd_data
);
  for (genvar g = 0; g < `SSBP_LANES; g++) begin : g_lane
    // one store per lane, so each lane has a single writer
    logic [`SSBP_LANE_W-1:0] lane_mem [`SSBP_DEPTH];

    // flow-through read: lane word goes straight out
    assign rd_data[g*`SSBP_LANE_W +: `SSBP_LANE_W] = lane_mem[addr];

    always_ff @(posedge clock) begin
      if (wr_en && wr_mask[g]) begin
        lane_mem[addr] <= wr_data[g*`SSBP_LANE_W +: `SSBP_LANE_W];
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/sync_burst_sram_port.sv
// synchronous flow-through burst sram port, 32k x 36
`timescale 1ns/1ns
`default_nettype none
`include "ssbp_defs.svh"
// Summary of operation
// - array holds 32K words of 36 bits in four byte lanes
// - address, data and controls captured on rising edge; oe and order not
// - either strobe low with enables active starts burst from external address
// - 2-bit burst counter supplies low address bits of later accesses
// - strobes high: advance low steps counter, advance high holds address
// - write begins at clock edge and completes internally, no write pulse needed
// - write enable low writes only lanes whose byte write is low
// - global write low writes all lanes, ignoring other write inputs
// - write when global write low or write enable plus a byte low
// - processor strobe ignored while primary chip enable is high
// - controller strobe with primary enable high deselects, data pins float
// - expansion enables inactive on accepted strobe deselect the device
// - controller start reads or writes per inputs; processor start reads
// - order select low: low bits count upward and wrap
// - order select high: start bits xor 00, 01, 10, 11
// - output enable acts asynchronously on the data drivers
// - read data flows from array to pins in the same cycle
module sync_burst_sram_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic [`SSBP_ADDR_W-1:0] addr_in,
  input wire logic proc_addr_strobe_n,
  input wire logic ctrl_addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic chip_en_primary_n,
  input wire logic chip_en_expand_hi,
  input wire logic chip_en_expand_lo_n,
  input wire logic write_en_n,
  input wire logic global_write_n,
  input wire logic [`SSBP_LANES-1:0] byte_write_n,
  input wire logic burst_order_sel,
  input wire logic out_en_n,
  input wire logic [`SSBP_DATA_W-1:0] data_lane_in,
  output logic [`SSBP_DATA_W-1:0] data_lane_out,
  output logic [`SSBP_DATA_W-1:0] data_lane_oe
);
  ssbp_pkg::ssbp_cycle_t cyc_q;
  ssbp_pkg::ssbp_cycle_t cyc_d;
  logic [`SSBP_HI_W-1:0] addr_hi_q;
  logic [`SSBP_HI_W-1:0] addr_hi_d;
  logic [`SSBP_CNT_W-1:0] base_q;
  logic [`SSBP_CNT_W-1:0] base_d;
  logic [`SSBP_CNT_W-1:0] cnt_q;
  logic [`SSBP_CNT_W-1:0] cnt_d;
  logic [`SSBP_DATA_W-1:0] wdata_q;
  logic [`SSBP_DATA_W-1:0] wdata_d;
  logic [`SSBP_LANES-1:0] wmask_q;
  logic [`SSBP_LANES-1:0] wmask_d;
  logic [`SSBP_CNT_W-1:0] addr_low_bits;
  logic [`SSBP_ADDR_W-1:0] cur_addr;
  logic [`SSBP_DATA_W-1:0] rd_word;
  logic chips_on;
  logic proc_take;
  logic ctrl_take;
  logic strobe_take;
  logic is_write;
  logic drive_on;

  // decode of the pins as seen at the coming edge
  assign chips_on = !chip_en_primary_n && chip_en_expand_hi && !chip_en_expand_lo_n;
  assign proc_take = !proc_addr_strobe_n && !chip_en_primary_n;
  assign ctrl_take = !ctrl_addr_strobe_n;
  assign strobe_take = proc_take || ctrl_take;
  assign is_write = !global_write_n || (!write_en_n && (byte_write_n != `SSBP_MASK_ALL));

  always_comb begin
    cyc_d = cyc_q;
    addr_hi_d = addr_hi_q;
    base_d = base_q;
    cnt_d = cnt_q;
    if (strobe_take) begin
      if (!chips_on) begin
        cyc_d = ssbp_pkg::CYC_DESEL;
      end else begin
        addr_hi_d = addr_in[`SSBP_HI_MSB:`SSBP_HI_LSB];
        base_d = addr_in[`SSBP_LOW_MSB:0];
        cnt_d = `SSBP_CNT_RST;
        if (proc_take) begin
          cyc_d = ssbp_pkg::CYC_READ;
        end else if (is_write) begin
          cyc_d = ssbp_pkg::CYC_WRITE;
        end else begin
          cyc_d = ssbp_pkg::CYC_READ;
        end
      end
    end else if (cyc_q != ssbp_pkg::CYC_DESEL) begin
      cyc_d = is_write ? ssbp_pkg::CYC_WRITE : ssbp_pkg::CYC_READ;
      if (!burst_advance_n) begin
        cnt_d = cnt_q + `SSBP_CNT_STEP;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cyc_q <= ssbp_pkg::CYC_DESEL;
      addr_hi_q <= '0;
      base_q <= `SSBP_CNT_RST;
      cnt_q <= `SSBP_CNT_RST;
    end else begin
      cyc_q <= cyc_d;
      addr_hi_q <= addr_hi_d;
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end

  // write data and lane mask captured at the edge that opens the write
  always_comb begin
    wdata_d = data_lane_in;
    if (!global_write_n) begin
      wmask_d = `SSBP_MASK_ALL;
    end else if (!write_en_n) begin
      wmask_d = ~byte_write_n;
    end else begin
      wmask_d = `SSBP_MASK_NONE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wdata_q <= '0;
      wmask_q <= `SSBP_MASK_NONE;
    end else begin
      wdata_q <= wdata_d;
      wmask_q <= wmask_d;
    end
  end

  // order select is used live, never sampled
  assign addr_low_bits = burst_order_sel ? (base_q ^ cnt_q) : (base_q + cnt_q);
  assign cur_addr = {addr_hi_q, addr_low_bits};

  // write lands at the edge closing the write cycle, no external pulse
  ssbp_array u_array (
    .clock(clock),
    .wr_en(cyc_q == ssbp_pkg::CYC_WRITE && !rst),
    .wr_mask(wmask_q),
    .wr_data(wdata_q),
    .addr(cur_addr),
    .rd_data(rd_word)
  );

  assign data_lane_out = rd_word;
  assign drive_on = (cyc_q == ssbp_pkg::CYC_READ) && !out_en_n;
  assign data_lane_oe = {`SSBP_DATA_W{drive_on}};

  // checks
  sequence s_load_ok;
    strobe_take && chips_on;
  endsequence

  sequence s_step;
    proc_addr_strobe_n && ctrl_addr_strobe_n && !burst_advance_n;
  endsequence

  property p_load;
    @(posedge clock) disable iff (rst)
    s_load_ok |=> (addr_hi_q == $past(addr_in[`SSBP_HI_MSB:`SSBP_HI_LSB]))
      && (base_q == $past(addr_in[`SSBP_LOW_MSB:0])) && (cnt_q == `SSBP_CNT_RST);
  endproperty
  a_load: assert property (p_load) else $error("burst start did not load address");

  property p_adv;
    @(posedge clock) disable iff (rst)
    ((cyc_q != ssbp_pkg::CYC_DESEL) and s_step)
      |=> cnt_q == $past(cnt_q) + `SSBP_CNT_STEP;
  endproperty
  a_adv: assert property (p_adv) else $error("advance did not step counter");

  property p_hold;
    @(posedge clock) disable iff (rst)
    proc_addr_strobe_n && ctrl_addr_strobe_n && burst_advance_n
      |=> $stable(cnt_q) && $stable(addr_hi_q);
  endproperty
  a_hold: assert property (p_hold) else $error("suspend moved the address");

  property p_proc_ignored;
    @(posedge clock) disable iff (rst)
    !proc_addr_strobe_n && chip_en_primary_n && ctrl_addr_strobe_n && burst_advance_n
      && (cyc_q != ssbp_pkg::CYC_DESEL) |=> (cyc_q != ssbp_pkg::CYC_DESEL) && $stable(base_q);
  endproperty
  a_proc_ignored: assert property (p_proc_ignored) else $error("blocked strobe acted");

  property p_desel;
    @(posedge clock) disable iff (rst)
    !ctrl_addr_strobe_n && chip_en_primary_n
      |=> (cyc_q == ssbp_pkg::CYC_DESEL) && (data_lane_oe == '0);
  endproperty
  a_desel: assert property (p_desel) else $error("controller strobe did not deselect");

  property p_expand;
    @(posedge clock) disable iff (rst)
    strobe_take && (!chip_en_expand_hi || chip_en_expand_lo_n)
      |=> cyc_q == ssbp_pkg::CYC_DESEL;
  endproperty
  a_expand: assert property (p_expand) else $error("expansion enable did not deselect");

  property p_proc_read;
    @(posedge clock) disable iff (rst)
    proc_take && chips_on |=> cyc_q == ssbp_pkg::CYC_READ;
  endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor start not a read");

  property p_ctrl_kind;
    @(posedge clock) disable iff (rst)
    ctrl_take && !proc_take && chips_on
      |=> (cyc_q == ssbp_pkg::CYC_WRITE) == $past(is_write);
  endproperty
  a_ctrl_kind: assert property (p_ctrl_kind) else $error("controller start wrong kind");

  property p_global;
    @(posedge clock) disable iff (rst)
    !global_write_n |=> wmask_q == `SSBP_MASK_ALL;
  endproperty
  a_global: assert property (p_global) else $error("global write missed a lane");

  property p_bytes;
    @(posedge clock) disable iff (rst)
    global_write_n && !write_en_n |=> wmask_q == ~$past(byte_write_n);
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte lanes wrong");

  property p_linear;
    @(posedge clock) disable iff (rst)
    (!burst_order_sel and s_load_ok) ##1 s_step [*3]
      |=> addr_low_bits == base_q + `SSBP_CNT_LAST;
  endproperty
  a_linear: assert property (p_linear) else $error("linear fourth address wrong");

  property p_interleave;
    @(posedge clock) disable iff (rst)
    (burst_order_sel and s_load_ok) ##1 s_step [*3]
      |=> addr_low_bits == (base_q ^ `SSBP_CNT_LAST);
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleaved address wrong");

  property p_write_quiet;
    @(posedge clock) disable iff (rst)
    cyc_q == ssbp_pkg::CYC_WRITE |-> data_lane_oe == '0;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("driving during write");

  property p_write_lands;
    @(posedge clock) disable iff (rst)
    (cyc_q == ssbp_pkg::CYC_WRITE) && (wmask_q == `SSBP_MASK_ALL) && $stable(cur_addr)
      ##1 (cyc_q == ssbp_pkg::CYC_READ) && (cur_addr == $past(cur_addr))
      |-> data_lane_out == $past(wdata_q);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  property p_desel_stays;
    @(posedge clock) disable iff (rst)
    (cyc_q == ssbp_pkg::CYC_DESEL) && !strobe_take |=> cyc_q == ssbp_pkg::CYC_DESEL;
  endproperty
  a_desel_stays: assert property (p_desel_stays) else $error("left deselect unasked");

  property p_desel_quiet;
    @(posedge clock) disable iff (rst)
    cyc_q == ssbp_pkg::CYC_DESEL |-> data_lane_oe == '0;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet) else $error("driving while deselected");

  property p_cont_kind;
    @(posedge clock) disable iff (rst)
    (cyc_q != ssbp_pkg::CYC_DESEL) && !strobe_take
      |=> (cyc_q == ssbp_pkg::CYC_WRITE) == $past(is_write);
  endproperty
  a_cont_kind: assert property (p_cont_kind) else $error("continued cycle wrong kind");

  property p_mask_none;
    @(posedge clock) disable iff (rst)
    global_write_n && write_en_n |=> wmask_q == `SSBP_MASK_NONE;
  endproperty
  a_mask_none: assert property (p_mask_none) else $error("lane mask set on a read");

  property p_data_taken;
    @(posedge clock) disable iff (rst)
    !global_write_n || !write_en_n |=> wdata_q == $past(data_lane_in);
  endproperty
  a_data_taken: assert property (p_data_taken) else $error("write data not captured");

  property p_addr_kept;
    @(posedge clock) disable iff (rst)
    !strobe_take |=> $stable(base_q) && $stable(addr_hi_q);
  endproperty
  a_addr_kept: assert property (p_addr_kept) else $error("start address moved");

  property p_oe_off;
    @(posedge clock) disable iff (rst)
    out_en_n |-> data_lane_oe == '0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving with output enable high");

  property p_read_drive;
    @(posedge clock) disable iff (rst)
    (cyc_q == ssbp_pkg::CYC_READ) && !out_en_n |-> data_lane_oe == '1;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
endmodule
`default_nettype wire

// ### verification/ssbp_ctrl_model.sv
// cache controller model that drives the burst sram port pins
`timescale 1ns/1ns
`default_nettype none
`include "ssbp_defs.svh"
module ssbp_ctrl_model (
  input wire logic clock,
  output var logic [`SSBP_ADDR_W-1:0] addr_in,
  output var logic proc_addr_strobe_n,
  output var logic ctrl_addr_strobe_n,
  output var logic burst_advance_n,
  output var logic chip_en_primary_n,
  output var logic chip_en_expand_hi,
  output var logic chip_en_expand_lo_n,
  output var logic write_en_n,
  output var logic global_write_n,
  output var logic [`SSBP_LANES-1:0] byte_write_n,
  output var logic out_en_n,
  output var logic [`SSBP_DATA_W-1:0] data_lane_in
);
  initial begin
    {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
    {chip_en_primary_n, chip_en_expand_hi, chip_en_expand_lo_n} = 3'h5;
    {write_en_n, global_write_n, out_en_n} = 3'h7;
    byte_write_n = 4'hF;
    addr_in = 15'h0000;
    data_lane_in = 36'h000000000;
  end
  // one bus cycle: set just after an edge, taken at the next
  task automatic drive(input logic ps_n, input logic cs_n, input logic adv_n,
    input logic [2:0] en, input logic gw_n, input logic we_n, input logic [3:0] bw_n,
    input logic [14:0] a, input logic [35:0] d, input logic oen);
    @(posedge clock);
    proc_addr_strobe_n <= ps_n;
    ctrl_addr_strobe_n <= cs_n;
    burst_advance_n <= adv_n;
    {chip_en_primary_n, chip_en_expand_hi, chip_en_expand_lo_n} <= en;
    {global_write_n, write_en_n, byte_write_n} <= {gw_n, we_n, bw_n};
    // unused address lines show the inverse of their last value
    addr_in <= (ps_n & cs_n) ? ~addr_in : a;
    data_lane_in <= d;
    out_en_n <= oen;
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the burst sram port
`timescale 1ns/1ns
`default_nettype none
`include "ssbp_defs.svh"
module testbench;
  logic clock, rst, burst_order_sel, oen_g;
  logic [14:0] addr_in;
  logic ps_n, cs_n, adv_n, se1_n, se2, se3_n, we_n, gw_n, oe_n;
  logic [3:0] bw_n;
  logic [35:0] din, data_lane_out, data_lane_oe, exp_v, wd;
  logic [35:0] mem [int];
  logic [35:0] expq [$];
  logic [15:0] seed = 16'h003C;
  int failures = 0;
  int samples_checked = 0;
  sync_burst_sram_port dut (.clock(clock), .rst(rst), .addr_in(addr_in),
    .proc_addr_strobe_n(ps_n), .ctrl_addr_strobe_n(cs_n), .burst_advance_n(adv_n),
    .chip_en_primary_n(se1_n), .chip_en_expand_hi(se2), .chip_en_expand_lo_n(se3_n),
    .write_en_n(we_n), .global_write_n(gw_n), .byte_write_n(bw_n),
    .burst_order_sel(burst_order_sel), .out_en_n(oe_n), .data_lane_in(din),
    .data_lane_out(data_lane_out), .data_lane_oe(data_lane_oe));
  ssbp_ctrl_model u_ctrl (.clock(clock), .addr_in(addr_in), .proc_addr_strobe_n(ps_n),
    .ctrl_addr_strobe_n(cs_n), .burst_advance_n(adv_n), .chip_en_primary_n(se1_n),
    .chip_en_expand_hi(se2), .chip_en_expand_lo_n(se3_n), .write_en_n(we_n),
    .global_write_n(gw_n), .byte_write_n(bw_n), .out_en_n(oe_n), .data_lane_in(din));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd(output logic [35:0] r);
    seed = lfsr(seed);
    r[15:0] = seed;
    seed = lfsr(seed);
    r[31:16] = seed;
    seed = lfsr(seed);
    r[35:32] = seed[3:0];
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] d,
    input logic [3:0] m);
    for (int l = 0; l < 4; l++) begin
      if (!m[l]) o[l*9+:9] = d[l*9+:9];
    end
    return o;
  endfunction
  // advs bit i: advance level of beat i; ign bit i: blocked processor strobe
  task automatic burst(input logic [14:0] base, input logic proc, input int n,
    input logic [7:0] advs, input logic [7:0] ign, input logic gw, input logic we,
    input logic [3:0] bw);
    logic [1:0] cnt;
    logic [14:0] a;
    logic [35:0] d;
    logic wr;
    logic oe_w;
    cnt = 2'h0;
    wr = !gw || (!we && bw != 4'hF);
    oe_w = wr | oen_g;
    for (int i = 0; i < n; i++) begin
      if (i > 0 && !advs[i]) cnt = cnt + 2'h1;
      a = {base[14:2], burst_order_sel ? base[1:0] ^ cnt : base[1:0] + cnt};
      rnd(d);
      if (i == 0) u_ctrl.drive(!proc, proc, 1'b1, 3'h2, gw, we, bw, base, d, oe_w);
      else u_ctrl.drive(!ign[i], 1'b1, advs[i], ign[i] ? 3'h6 : 3'h2, gw, we, bw, d[14:0],
        d, oe_w);
      if (wr) mem[a] = merge(mem.exists(a) ? mem[a] : 36'h0, d, gw ? bw : 4'h0);
      else if (!oen_g) expq.push_back(mem[a]);
    end
    u_ctrl.drive(1'b1, 1'b0, 1'b1, 3'h6, 1'b1, 1'b1, 4'hF, base, d, oe_w);
  endtask
  // failed start with write inputs low: nothing driven, nothing stored
  task automatic desel(input logic proc, input logic [2:0] en);
    logic [35:0] d;
    rnd(d);
    u_ctrl.drive(!proc, proc, 1'b1, en, 1'b0, 1'b0, 4'h0, 15'h0101, d, oen_g);
    u_ctrl.drive(1'b1, 1'b1, 1'b0, 3'h2, 1'b0, 1'b0, 4'h0, 15'h0101, d, oen_g);
  endtask
  task automatic stop_test();
    if (expq.size() != 0) begin
      failures++;
      $display("CHECK FAILED pending reads expected 0 seen %0d", expq.size());
    end
    if (failures == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(negedge clock) begin
    if (!rst && data_lane_oe !== 36'h000000000) begin
      samples_checked++;
      if (expq.size() == 0 || data_lane_oe !== 36'hFFFFFFFFF) begin
        failures++;
        $display("CHECK FAILED data_lane_oe expected 0 seen %h", data_lane_oe);
      end else begin
        exp_v = expq.pop_front();
        if (data_lane_out !== exp_v) begin
          failures++;
          $display("CHECK FAILED data_lane_out expected %h seen %h", exp_v, data_lane_out);
        end
      end
    end
  end
  // whole run is under 200 cycles
  initial begin
    #20000;
    failures++;
    stop_test();
  end
  initial begin
    rst = 1'b1;
    burst_order_sel = 1'b0;
    oen_g = 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    burst(15'h0101, 1'b0, 4, 8'h00, 8'h00, 1'b0, 1'b1, 4'hF);
    burst(15'h0102, 1'b0, 6, 8'h0C, 8'h08, 1'b1, 1'b1, 4'hF);
    @(posedge clock);
    burst_order_sel <= 1'b1;
    burst(15'h0101, 1'b1, 4, 8'h00, 8'h00, 1'b1, 1'b1, 4'hF);
    burst(15'h0102, 1'b0, 2, 8'h00, 8'h00, 1'b1, 1'b0, 4'hA);
    burst(15'h0103, 1'b0, 1, 8'h00, 8'h00, 1'b1, 1'b1, 4'h0);
    for (int l = 0; l < 4; l++) begin
      burst(15'h0100, 1'b0, 1, 8'h00, 8'h00, 1'b1, 1'b0, ~(4'h1 << l));
    end
    // global write, then the same word read back with the address held
    rnd(wd);
    u_ctrl.drive(1'b1, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1, 4'hF, 15'h0100, wd, 1'b1);
    mem[15'h0100] = wd;
    u_ctrl.drive(1'b1, 1'b1, 1'b1, 3'h2, 1'b1, 1'b1, 4'hF, 15'h0100, wd, 1'b1);
    expq.push_back(wd);
    u_ctrl.drive(1'b1, 1'b0, 1'b1, 3'h6, 1'b1, 1'b1, 4'hF, 15'h0100, wd, 1'b0);
    desel(1'b0, 3'h6);
    desel(1'b0, 3'h0);
    desel(1'b0, 3'h3);
    desel(1'b1, 3'h0);
    desel(1'b1, 3'h6);
    oen_g = 1'b1;
    burst(15'h0100, 1'b0, 4, 8'h00, 8'h00, 1'b1, 1'b1, 4'hF);
    oen_g = 1'b0;
    burst(15'h0100, 1'b0, 4, 8'h00, 8'h00, 1'b1, 1'b1, 4'hF);
    repeat (3) @(posedge clock);
    stop_test();
  end
endmodule
`default_nettype wire
